// ---- core/cptd_consts.vh ----
// Constants for the cam parameter table decoder
`ifndef CPTD_CONSTS_VH
`define CPTD_CONSTS_VH
// ================
// Register byte offsets on the AHB-Lite slave
`define CPTD_OFF_CMD     8'h00
`define CPTD_OFF_DATA0   8'h04
`define CPTD_OFF_DATA1   8'h08
`define CPTD_OFF_DATA2   8'h0c
`define CPTD_OFF_CTRL    8'h10
`define CPTD_OFF_STATUS  8'h14
`define CPTD_OFF_SELECT  8'h18
`define CPTD_OFF_DIRCAM  8'h1c
// ================
// Field positions
`define CPTD_WRITE_REQ_BIT 15
`define CPTD_CTRL_START_BIT 0
`define CPTD_TEACH_BIT   0
`define CPTD_INVERT_BIT  1
`define CPTD_QUIT_BIT    2
// ================
// Descriptor type codes
`define CPTD_TYPE_DIR    16'h0001
`define CPTD_TYPE_ST     16'h0003
`define CPTD_TYPE_IDLE   16'h0004
`define CPTD_TYPE_CTRL   16'h0005
`define CPTD_TYPE_MT     16'h0007
`define CPTD_TYPE_DIRCAM 16'h0008
// ================
// Sizes in bytes and table limits
`define CPTD_DESC_SIZE   16'h0006
`define CPTD_ST_SIZE     16'h0006
`define CPTD_MT_SIZE     16'h000c
`define CPTD_TABLE_WORDS 64
`define CPTD_TABLE_BYTES 16'h0080
// ================
// Record kinds on the decoded record port
`define CPTD_KIND_ST     2'h0
`define CPTD_KIND_IDLE   2'h1
`define CPTD_KIND_MT     2'h2
// ================
// Reset values
`define CPTD_DIR_RESET   16'hffff
`define CPTD_ZERO16      16'h0000
`endif

// ---- core/cptd_record_unpack.v ----
// Splits one cam or idle-time record into its fields
`default_nettype none
`include "cptd_consts.vh"
module cptd_record_unpack (
  input  wire [1:0]  kind,         // Record kind being walked
  input  wire [15:0] w0,           // Record word 0
  input  wire [15:0] w1,           // Record word 1
  input  wire [15:0] w2,           // Record word 2
  input  wire [15:0] w3,           // Record word 3
  input  wire [15:0] w4,           // Record word 4
  input  wire [15:0] w5,           // Record word 5
  output reg  [7:0]  program_number, // Program the record belongs to
  output reg  [15:0] output_number,  // Output the record drives
  output reg  [31:0] on_value,       // On position or switch-on delay
  output reg  [31:0] off_value,      // Off position or switch-off delay
  output reg         delete          // Record removes its entry
);
  // ================
  // Field split per kind; first byte of a word is its high byte
  always @* begin
    program_number = w0[15:8];
    output_number  = {8'h00, w0[7:0]};
    on_value       = {16'h0000, w1};
    off_value      = {16'h0000, w2};
    delete         = 1'b0;
    case (kind)
      `CPTD_KIND_ST: begin
        // Zero output or both switching points zero delete it
        delete = (w0[7:0] == 8'h00) || // [R06]
                 ((w1 == 16'h0000) && (w2 == 16'h0000)); // [R07]
      end
      `CPTD_KIND_IDLE: begin
        // Both delays zero delete the idle time
        delete = (w1 == 16'h0000) && (w2 == 16'h0000);
      end
      `CPTD_KIND_MT: begin
        // Word program, word output, 32-bit on and off
        program_number = w0[7:0]; // [R15]
        output_number  = w1;
        on_value       = {w2, w3};
        off_value      = {w4, w5};
        delete         = (w1 == 16'h0000); // [R15]
      end
      default: delete = 1'b0;
    endcase
  end
endmodule // cptd_record_unpack
`default_nettype wire

// ---- core/cptd_table_decoder.v ----
// Parameter table store and descriptor decoder with AHB-Lite registers
//
// Notes on behaviour
// [R01] Descriptors are three words: type, length, address
// [R02] Directory recognised by type 0x0001 at start
// [R03] Master puts directory at table address zero
// [R04] Tables located only through directory descriptors
// [R05] Type 3: single-turn cams, six bytes each
// [R06] Cam record: program, output; zero output deletes
// [R07] On and off both zero deletes cam
// [R08] Type 4: idle-time records, six bytes each
// [R09] Master packs idle-time records without gaps
// [R10] Type 5: control table, six bytes fixed
// [R11] Control: program select, flags, reserved ignored
// [R12] Flag bit 0 teaches current position zero
// [R13] Flag bit 1 inverts encoder counting direction
// [R14] Type 7: multiturn cams, twelve bytes each
// [R15] Multiturn record words; zero output deletes
// [R16] Type 8: direction-cam table, six bytes
// [R17] Forward enables word, reverse word, reserved
// [R18] Enable pair selects none, one or both
// [R19] Default: every output updates both directions
// [R20] Master sends six-byte chunks with write request
// [R21] Unsupported descriptor types are skipped
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`default_nettype none
`include "cptd_consts.vh"
module cptd_table_decoder (
  input  wire        clk,             // System clock, 100 MHz
  input  wire        rst_n,           // Asynchronous reset, active low
  input  wire        hsel,            // AHB-Lite slave select
  input  wire [31:0] haddr,           // AHB-Lite address
  input  wire [1:0]  htrans,          // AHB-Lite transfer type
  input  wire        hwrite,          // AHB-Lite write flag
  input  wire [2:0]  hsize,           // AHB-Lite transfer size
  input  wire [31:0] hwdata,          // AHB-Lite write data
  input  wire        hready,          // AHB-Lite bus ready
  output wire        hreadyout,       // Slave ready, always high
  output wire        hresp,           // Slave response, always OKAY
  output reg  [31:0] hrdata,          // Read data
  output reg         rec_valid,       // One-cycle pulse per record
  output reg  [1:0]  rec_kind,        // Kind of emitted record
  output reg  [7:0]  program_number,  // Program of emitted record
  output reg  [15:0] output_number,   // Output of emitted record
  output reg  [31:0] rec_on,          // On position or switch_on_delay
  output reg  [31:0] rec_off,         // Off position or switch_off_delay
  output reg         rec_delete,      // Emitted record deletes entry
  output reg  [7:0]  program_select,  // Active program chosen
  output reg         teach_zero,      // Pulse: teach zero point
  output reg         invert_count,    // Level: encoder count inverted
  output reg         error_quit,      // Pulse: acknowledge error
  output reg  [15:0] out_forward_enable, // Bit n: out n+1 forward
  output reg  [15:0] out_reverse_enable  // Bit n: out n+1 reverse
);
  // ================
  // Decoder states
  localparam [1:0] S_IDLE = 2'b00; // Waiting for start
  localparam [1:0] S_HEAD = 2'b01; // Checking directory header
  localparam [1:0] S_DESC = 2'b10; // Reading one descriptor
  localparam [1:0] S_REC  = 2'b11; // Walking records of a table

  reg  [15:0] table_mem [0:`CPTD_TABLE_WORDS-1]; // Parameter table
  reg  [15:0] stage0;          // Staged chunk word 0
  reg  [15:0] stage1;          // Staged chunk word 1
  reg  [15:0] stage2;          // Staged chunk word 2
  reg  [15:0] cmd_echo;        // Last accepted chunk command
  reg         addr_error;      // Sticky: chunk address refused
  reg         dir_error;       // Sticky: no directory at start
  reg  [7:0]  skip_count;      // Unsupported descriptors seen
  reg         done;            // Decode pass finished
  reg  [1:0]  state;           // Decoder state
  reg  [15:0] dir_len;         // Directory byte length
  reg  [15:0] dptr;            // Byte pointer to next descriptor
  reg  [15:0] rptr;            // Byte pointer to next record
  reg  [15:0] rend;            // Byte end of current table
  reg  [15:0] rsize;           // Record size of current table
  reg  [1:0]  kind;            // Kind of current table
  reg         ph_write;        // Data phase is a write
  reg  [7:0]  ph_addr;         // Data phase register offset
  integer     i;               // Loop index for table reset

  // ================
  // Table read by byte pointer plus word offset
  function [15:0] rd;
    input [15:0] bptr;
    input [5:0]  woff;
    reg   [5:0]  idx;
    begin
      idx = bptr[6:1] + woff;
      rd  = table_mem[idx];
    end
  endfunction

  // Pointer and size fit inside the table store
  function fits;
    input [15:0] bptr;
    input [15:0] size;
    begin
      fits = (size <= `CPTD_TABLE_BYTES) &&
             (bptr <= (`CPTD_TABLE_BYTES - size)) && !bptr[0];
    end
  endfunction

  wire [15:0] d_type = rd(dptr, 6'd0); // Descriptor type code
  wire [15:0] d_len  = rd(dptr, 6'd1); // Descriptor byte length
  wire [15:0] d_addr = rd(dptr, 6'd2); // Descriptor start address
  wire [15:0] ctrl_word = rd(d_addr, 6'd0); // Control table first word
  wire        addr_phase = hsel & htrans[1] & hready; // Request taken
  wire        start = ph_write && (ph_addr == `CPTD_OFF_CTRL) &&
                      hwdata[`CPTD_CTRL_START_BIT];
  wire [15:0] cmd_word = hwdata[15:0]; // Chunk command word
  wire        cmd_wr = ph_write && (ph_addr == `CPTD_OFF_CMD);
  wire [7:0]  u_prog;          // Unpacked program number
  wire [15:0] u_out;           // Unpacked output number
  wire [31:0] u_on;            // Unpacked on value
  wire [31:0] u_off;           // Unpacked off value
  wire        u_del;           // Unpacked delete flag

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ================
  // Record field split for the record under the pointer
  cptd_record_unpack u_unpack (
    .kind           (kind),
    .w0             (rd(rptr, 6'd0)),
    .w1             (rd(rptr, 6'd1)),
    .w2             (rd(rptr, 6'd2)),
    .w3             (rd(rptr, 6'd3)),
    .w4             (rd(rptr, 6'd4)),
    .w5             (rd(rptr, 6'd5)),
    .program_number (u_prog),
    .output_number  (u_out),
    .on_value       (u_on),
    .off_value      (u_off),
    .delete         (u_del)
  );

  // ================
  // AHB-Lite address phase capture and registered read data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
      hrdata   <= 32'h00000000;
    end else begin
      ph_write <= addr_phase & hwrite;
      ph_addr  <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        // Read value is ready in the data phase
        case (haddr[7:0])
          `CPTD_OFF_CMD:    hrdata <= {16'h0000, cmd_echo};
          `CPTD_OFF_DATA0:  hrdata <= {16'h0000, stage0};
          `CPTD_OFF_DATA1:  hrdata <= {16'h0000, stage1};
          `CPTD_OFF_DATA2:  hrdata <= {16'h0000, stage2};
          `CPTD_OFF_STATUS: hrdata <= {20'h00000, skip_count, dir_error,
                                       addr_error, done,
                                       (state != S_IDLE)};
          `CPTD_OFF_SELECT: hrdata <= {21'h000000, error_quit,
                                       invert_count, teach_zero,
                                       program_select};
          `CPTD_OFF_DIRCAM: hrdata <= {out_reverse_enable,
                                       out_forward_enable};
          default:          hrdata <= 32'h00000000; // Unmapped
        endcase
      end
    end
  end

  // ================
  // Chunk staging and table writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage0     <= `CPTD_ZERO16;
      stage1     <= `CPTD_ZERO16;
      stage2     <= `CPTD_ZERO16;
      cmd_echo   <= `CPTD_ZERO16;
      addr_error <= 1'b0;
      for (i = 0; i < `CPTD_TABLE_WORDS; i = i + 1) begin
        table_mem[i] <= `CPTD_ZERO16;
      end
    end else begin
      if (ph_write && (ph_addr == `CPTD_OFF_DATA0)) begin
        stage0 <= hwdata[15:0];
      end
      if (ph_write && (ph_addr == `CPTD_OFF_DATA1)) begin
        stage1 <= hwdata[15:0];
      end
      if (ph_write && (ph_addr == `CPTD_OFF_DATA2)) begin
        stage2 <= hwdata[15:0];
      end
      if (ph_write && (ph_addr == `CPTD_OFF_STATUS) && hwdata[2]) begin
        addr_error <= 1'b0; // Write one clears
      end
      if (cmd_wr && cmd_word[`CPTD_WRITE_REQ_BIT]) begin
        // Three data words land at the chunk address
        if (fits({2'b00, cmd_word[13:0]}, `CPTD_DESC_SIZE)) begin // [R20]
          table_mem[cmd_word[6:1]]               <= stage0;
          table_mem[cmd_word[6:1] + 6'd1]        <= stage1;
          table_mem[cmd_word[6:1] + 6'd2]        <= stage2;
          cmd_echo <= cmd_word; // Echo confirms receipt
        end else begin
          addr_error <= 1'b1; // Set wins over clear
        end
      end
    end
  end

  // ================
  // Directory walk and descriptor decode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= S_IDLE;
      done               <= 1'b0;
      dir_error          <= 1'b0;
      skip_count         <= 8'h00;
      dir_len            <= `CPTD_ZERO16;
      dptr               <= `CPTD_ZERO16;
      rptr               <= `CPTD_ZERO16;
      rend               <= `CPTD_ZERO16;
      rsize              <= `CPTD_ST_SIZE;
      kind               <= `CPTD_KIND_ST;
      rec_valid          <= 1'b0;
      rec_kind           <= `CPTD_KIND_ST;
      program_number     <= 8'h00;
      output_number      <= `CPTD_ZERO16;
      rec_on             <= 32'h00000000;
      rec_off            <= 32'h00000000;
      rec_delete         <= 1'b0;
      program_select     <= 8'h00;
      teach_zero         <= 1'b0;
      invert_count       <= 1'b0;
      error_quit         <= 1'b0;
      out_forward_enable <= `CPTD_DIR_RESET; // [R19]
      out_reverse_enable <= `CPTD_DIR_RESET; // [R19]
    end else begin
      rec_valid  <= 1'b0;
      teach_zero <= 1'b0;
      error_quit <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            state      <= S_HEAD;
            done       <= 1'b0;
            dir_error  <= 1'b0;
            skip_count <= 8'h00;
            dptr       <= `CPTD_ZERO16; // [R03]
          end
        end
        S_HEAD: begin
          // Directory declares itself in the first three words
          if (d_type == `CPTD_TYPE_DIR) begin // [R02]
            dir_len <= d_len;
            dptr    <= `CPTD_DESC_SIZE; // [R01]
            state   <= S_DESC;
          end else begin
            dir_error <= 1'b1;
            done      <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_DESC: begin
          // Tables found only through the directory
          if ((dptr >= dir_len) || !fits(dptr, `CPTD_DESC_SIZE)) begin // [R04]
            done  <= 1'b1;
            state <= S_IDLE;
          end else begin
            dptr <= dptr + `CPTD_DESC_SIZE; // [R01]
            rptr <= d_addr;
            rend <= d_addr + d_len;
            case (d_type)
              `CPTD_TYPE_ST: begin
                kind  <= `CPTD_KIND_ST; // [R05]
                rsize <= `CPTD_ST_SIZE;
                state <= S_REC;
              end
              `CPTD_TYPE_IDLE: begin
                kind  <= `CPTD_KIND_IDLE; // [R08]
                rsize <= `CPTD_ST_SIZE;
                state <= S_REC;
              end
              `CPTD_TYPE_MT: begin
                kind  <= `CPTD_KIND_MT; // [R14]
                rsize <= `CPTD_MT_SIZE;
                state <= S_REC;
              end
              `CPTD_TYPE_CTRL: begin
                // Program byte, flags byte; reserved bytes unused
                if ((d_len == `CPTD_DESC_SIZE) &&
                    fits(d_addr, `CPTD_DESC_SIZE)) begin // [R10]
                  program_select <= ctrl_word[15:8]; // [R11]
                  teach_zero     <= ctrl_word[`CPTD_TEACH_BIT]; // [R12]
                  invert_count   <= ctrl_word[`CPTD_INVERT_BIT]; // [R13]
                  error_quit     <= ctrl_word[`CPTD_QUIT_BIT];
                end
              end
              `CPTD_TYPE_DIRCAM: begin
                // Pair per output: forward bit, reverse bit
                if ((d_len == `CPTD_DESC_SIZE) &&
                    fits(d_addr, `CPTD_DESC_SIZE)) begin // [R16]
                  out_forward_enable <= rd(d_addr, 6'd0); // [R17] [R18]
                  out_reverse_enable <= rd(d_addr, 6'd1); // [R17] [R18]
                end
              end
              default: begin
                skip_count <= skip_count + 8'h01; // [R21]
              end
            endcase
          end
        end
        S_REC: begin
          // One record per cycle until the table end
          if ((rptr >= rend) || (rend - rptr < rsize) ||
              !fits(rptr, rsize)) begin // [R05] [R08] [R14]
            state <= S_DESC;
          end else begin
            rec_valid      <= 1'b1;
            rec_kind       <= kind;
            program_number <= u_prog; // [R06]
            output_number  <= u_out;
            rec_on         <= u_on;
            rec_off        <= u_off;
            rec_delete     <= u_del; // [R06] [R07] [R15]
            rptr           <= rptr + rsize;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // cptd_table_decoder
`default_nettype wire

// ---- tb/cptd_table_monitor.sv ----
// Checker on the ports of the parameter table decoder
`default_nettype none
module cptd_table_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        rec_valid,
  input wire logic [1:0]  rec_kind,
  input wire logic [15:0] output_number,
  input wire logic [31:0] rec_on,
  input wire logic [31:0] rec_off,
  input wire logic        rec_delete,
  input wire logic        teach_zero,
  input wire logic        invert_count,
  input wire logic [15:0] out_forward_enable,
  input wire logic [15:0] out_reverse_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ================
  // Helper: cycles since a decode start was written
  logic       ctrl_ap;   // Address phase to the start register
  logic [7:0] since_go;  // Saturates at ff when idle
  // Track the start write through its data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ap  <= 1'b0;
      since_go <= 8'hff;
    end else begin
      ctrl_ap <= hsel && htrans[1] && hready && hwrite &&
                 haddr[7:0] == 8'h10;
      if (ctrl_ap && hwdata[0]) begin
        since_go <= 8'h00;
      end else if (since_go != 8'hff) begin
        since_go <= since_go + 8'h01;
      end
    end
  end
  // ================
  // Sequences and assertions
  sequence s_rec_st;
    rec_valid && rec_kind == 2'h0;
  endsequence
  sequence s_rec_mt;
    rec_valid && rec_kind == 2'h2;
  endsequence
  a_default_both_ways: assert property (
    $rose(rst_n) |-> out_forward_enable == 16'hffff &&
    out_reverse_enable == 16'hffff) else $error("enables not set");
  a_st_zero_out: assert property (
    s_rec_st ##0 output_number == 16'h0000 |-> rec_delete)
    else $error("cam with output zero kept");
  a_st_live_kept: assert property (
    s_rec_st ##0 output_number != 16'h0000 && (rec_on | rec_off) != 0
    |-> !rec_delete) else $error("live cam deleted");
  a_zero_points_delete: assert property (
    rec_valid && rec_kind != 2'h2 && rec_on == 0 && rec_off == 0
    |-> rec_delete) else $error("zero points not deleted");
  a_mt_delete_match: assert property (
    s_rec_mt |-> rec_delete == (output_number == 16'h0000))
    else $error("multiturn delete wrong");
  a_short_fields: assert property (
    rec_valid && rec_kind != 2'h2 |-> rec_on[31:16] == 16'h0000 &&
    rec_off[31:16] == 16'h0000) else $error("short record widened");
  a_records_after_go: assert property (
    rec_valid |-> since_go < 8'd200) else $error("record without decode");
  a_teach_one_pulse: assert property (
    teach_zero |-> since_go < 8'd200 ##1 !teach_zero)
    else $error("teach pulse wrong");
  a_invert_after_go: assert property (
    $changed(invert_count) |-> since_go < 8'd200)
    else $error("invert changed without decode");
  a_enables_after_go: assert property (
    $changed({out_forward_enable, out_reverse_enable})
    |-> since_go < 8'd200) else $error("enables changed without decode");
endmodule // cptd_table_monitor
bind cptd_table_decoder cptd_table_monitor cptd_table_monitor_i (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .rec_valid(rec_valid), .rec_kind(rec_kind),
  .output_number(output_number), .rec_on(rec_on), .rec_off(rec_off),
  .rec_delete(rec_delete), .teach_zero(teach_zero),
  .invert_count(invert_count), .out_forward_enable(out_forward_enable),
  .out_reverse_enable(out_reverse_enable));
`default_nettype wire

// ---- tb/cptd_plc_model.sv ----
// Fieldbus master model: holds the table and copies it in chunks
`default_nettype none
`include "cptd_consts.vh"
module cptd_plc_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] tbl [0:63];  // Parameter table image, word k at byte 2k
  // Bus idle at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    foreach (tbl[i]) tbl[i] = 16'h0000;
  end
  // One single word transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Three words staged, then the write request; starts at zero
  task automatic copy_table(input int nbytes);
    logic [31:0] x;
    for (int a = 0; a < nbytes; a += 6) begin
      for (int k = 0; k < 3; k++) begin
        bus(1'b1, {24'h0, `CPTD_OFF_DATA0} + 32'(4 * k),
            {16'h0, tbl[a / 2 + k]}, x);
      end
      bus(1'b1, {24'h0, `CPTD_OFF_CMD}, 32'h8000 | 32'(a), x);
    end
  endtask
endmodule // cptd_plc_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the parameter table decoder
`default_nettype none
`include "cptd_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ================
  // Signals and counters
  logic        clk, rst_n;
  wire         hsel, hwrite, hreadyout, hresp, rec_valid, rec_delete;
  wire         teach_zero, invert_count, error_quit;
  wire  [1:0]  htrans, rec_kind;
  wire  [2:0]  hsize;
  wire  [7:0]  program_number, program_select;
  wire  [15:0] output_number, out_forward_enable, out_reverse_enable;
  wire  [31:0] haddr, hwdata, hrdata, rec_on, rec_off;
  int          err_count, total_checks, teach_seen, quit_seen;
  logic [90:0] rec_q [$];  // Records as emitted
  logic [31:0] st;         // Last register read
  // Table image: directory, two cams, idle, control, multiturn, dircam
  localparam logic [15:0] IMG [42] = '{
    16'h0001, 16'h002a, 16'h0000, 16'h0003, 16'h000c, 16'h002a, 16'h0004,
    16'h0006, 16'h0036, 16'h0005, 16'h0006, 16'h003c, 16'h0007, 16'h000c,
    16'h0042, 16'h0008, 16'h0006, 16'h004e, 16'h000b, 16'h0006, 16'h0000,
    16'h0205, 16'h0100, 16'h0200, 16'h0100, 16'h0005, 16'h0006, 16'h0304,
    16'h0000, 16'h0000, 16'h0703, 16'h0000, 16'h0000, 16'h0004, 16'h0009,
    16'h0001, 16'h2345, 16'h0002, 16'h3456, 16'h00a5, 16'h0f0f, 16'h0000};
  // ================
  // Design and fieldbus master
  cptd_table_decoder cptd_table_decoder_i (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rec_valid(rec_valid), .rec_kind(rec_kind),
    .program_number(program_number), .output_number(output_number),
    .rec_on(rec_on), .rec_off(rec_off), .rec_delete(rec_delete),
    .program_select(program_select), .teach_zero(teach_zero),
    .invert_count(invert_count), .error_quit(error_quit),
    .out_forward_enable(out_forward_enable),
    .out_reverse_enable(out_reverse_enable));
  cptd_plc_model cptd_plc_model_i (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  // ================
  // Shared tasks
  task automatic check(input string nm, input logic [95:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    cptd_plc_model_i.bus(1'b1, {24'h0, a}, d, st);
  endtask
  task automatic reg_rd(input logic [7:0] a);
    cptd_plc_model_i.bus(1'b0, {24'h0, a}, 32'h0, st);
  endtask
  // Start a pass and poll until done with busy low
  task automatic decode();
    rec_q.delete();
    reg_wr(`CPTD_OFF_CTRL, 32'h1);
    for (int i = 0; i < 80; i++) begin
      reg_rd(`CPTD_OFF_STATUS);
      if (st[1:0] === 2'b10) break;
    end
    check("done", st[1:0], 2'b10);
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ================
  // Scenarios
  task automatic t_reset();
    check("fwd at reset", out_forward_enable, 16'hffff);
    check("ready resp", {hreadyout, hresp}, 2'b10);
    reg_rd(`CPTD_OFF_DIRCAM);
    check("dircam at reset", st, 32'hffffffff);
    reg_wr(8'h40, 32'h1234);
    reg_rd(8'h40);
    check("unmapped", st, 32'h0);
  endtask
  task automatic t_bad_chunk();
    reg_wr(`CPTD_OFF_CMD, 32'h8003);
    reg_rd(`CPTD_OFF_STATUS);
    check("odd chunk", st[2], 1'b1);
    reg_wr(`CPTD_OFF_STATUS, 32'h4);
    reg_rd(`CPTD_OFF_STATUS);
    check("error cleared", st[2], 1'b0);
    reg_wr(`CPTD_OFF_CMD, 32'h807c);
    reg_rd(`CPTD_OFF_STATUS);
    check("chunk past end", st[2], 1'b1);
    reg_wr(`CPTD_OFF_STATUS, 32'h4);
  endtask
  task automatic t_full();
    logic [90:0] exp [4];
    exp = '{{2'h0, 8'h02, 16'h5, 32'h100, 32'h200, 1'b0},
            {2'h0, 8'h01, 16'h0, 32'h5, 32'h6, 1'b1},
            {2'h1, 8'h03, 16'h4, 32'h0, 32'h0, 1'b1},
            {2'h2, 8'h04, 16'h9, 32'h12345, 32'h23456, 1'b0}};
    foreach (IMG[i]) cptd_plc_model_i.tbl[i] = IMG[i];
    cptd_plc_model_i.copy_table(84);
    reg_rd(`CPTD_OFF_CMD);
    check("echo", st[15:0], 16'h804e);
    decode();
    check("status", st[11:0], 12'h012);
    check("records", rec_q.size(), 4);
    foreach (exp[i]) check("record", rec_q[i], exp[i]);
    check("program", program_select, 8'h07);
    check("invert", invert_count, 1'b1);
    check("teach", teach_seen, 1);
    check("fwd", out_forward_enable, 16'h00a5);
    reg_rd(`CPTD_OFF_DIRCAM);
    check("dircam", st, 32'h0f0f00a5);
  endtask
  task automatic t_bad_dir();
    cptd_plc_model_i.tbl[0] = 16'h0002;
    cptd_plc_model_i.copy_table(6);
    decode();
    check("dir error", st[3], 1'b1);
    check("no records", rec_q.size(), 0);
  endtask
  task automatic t_flags();
    cptd_plc_model_i.tbl[0] = 16'h0001;
    cptd_plc_model_i.tbl[30] = 16'h0f04;
    cptd_plc_model_i.tbl[31] = 16'hffff;
    cptd_plc_model_i.tbl[32] = 16'hffff;
    cptd_plc_model_i.copy_table(84);
    decode();
    check("dir ok", st[3], 1'b0);
    check("program", program_select, 8'h0f);
    check("invert", invert_count, 1'b0);
    check("quit", quit_seen, 1);
    check("teach", teach_seen, 1);
  endtask
  // ================
  // Clock, record capture, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rec_valid === 1'b1) rec_q.push_back({rec_kind, program_number,
        output_number, rec_on, rec_off, rec_delete});
    if (teach_zero === 1'b1) teach_seen++;
    if (error_quit === 1'b1) quit_seen++;
  end
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bad_chunk();
    t_full();
    t_bad_dir();
    t_flags();
    complete_run();
  end
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
